/* File: bench/osc_source_model.sv */
`timescale 1ns/1ps
// Oscillator sources: each one settles a fixed number of cycles after enable
module osc_source_model
  import power_mode_pkg::*;
#(
  parameter int SETTLE = 6
)
(
  input wire logic clk_i,
  input wire osc_vec_t osc_en_i,
  output osc_vec_t osc_ready_o
);
  // Settle counters, one per source; start at zero so no unknown lingers
  logic [3:0][3:0] cnt_reg = '0;
  // Counter clears when disabled, saturates at 4'hf
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!osc_en_i[i])
        cnt_reg[i] <= 4'h0;
      else if (cnt_reg[i] != 4'hf)
        cnt_reg[i] <= cnt_reg[i] + 4'h1;
    end
  end
  // Ready drops at once when stopped, rises only after settling
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      osc_ready_o[i] = osc_en_i[i] && (cnt_reg[i] >= SETTLE[3:0]);
  end
endmodule : osc_source_model

/* File: bench/power_mode_controller_tb.sv */
`timescale 1ns/1ps
`include "power_mode_map.svh"
module power_mode_controller_tb;
  import power_mode_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, halt_i = 1'b0, clr_wdt_i = 1'b0, stack_full_i = 1'b0;
  logic wdt_overflow_i = 1'b0;
  logic [7:0] irq_req_i = 8'h00, irq_en_i = 8'h00;
  logic [7:0] port_pin_i = 8'hff; // Pins idle high
  osc_vec_t osc_ready_i, osc_en_o;
  logic cpu_clk_en_o, hs_clk_gate_o, sub_clk_gate_o, wdt_clear_o;
  logic wake_o, irq_take_o, pc_sp_reset_o;
  logic [2:0] sys_clk_select_o;
  int n_mismatch = 0;
  int total_checks = 0;
  // 25 MHz clock
  always #20 clk_i = ~clk_i;
  power_mode_controller uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .halt_i(halt_i), .clr_wdt_i(clr_wdt_i), .irq_req_i(irq_req_i), .irq_en_i(irq_en_i),
    .stack_full_i(stack_full_i), .wdt_overflow_i(wdt_overflow_i),
    .port_pin_i(port_pin_i), .osc_ready_i(osc_ready_i), .cpu_clk_en_o(cpu_clk_en_o),
    .hs_clk_gate_o(hs_clk_gate_o), .sub_clk_gate_o(sub_clk_gate_o),
    .sys_clk_select_o(sys_clk_select_o), .osc_en_o(osc_en_o), .wdt_clear_o(wdt_clear_o),
    .wake_o(wake_o), .irq_take_o(irq_take_o), .pc_sp_reset_o(pc_sp_reset_o));
  osc_source_model osc (.clk_i(clk_i), .osc_en_i(osc_en_o), .osc_ready_o(osc_ready_i));
  // Single closing point of the run
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // A wait that ran out of patience
  task fail_timeout;
    chk(32'h0, 32'h1);
    tally_and_finish();
  endtask : fail_timeout
  // Classic single cycle; hold until ack seen, release at the next edge
  task wb_xfer(input logic w, input logic [7:0] adr, input logic [7:0] wd,
               output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, wd};
    @(posedge clk_i);
    #1;
    while (wb_ack_o !== 1'b1)
    begin
      if (n > 20)
        fail_timeout();
      n++;
      @(posedge clk_i);
      #1;
    end
    rd = wb_dat_o[7:0];
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_xfer
  // Poll status until no clock switch is in progress
  task wait_switch;
    logic [7:0] s;
    int n;
    n = 0;
    s = 8'hff;
    repeat (3) @(posedge clk_i);
    while (s[`STAT_BUSY] !== 1'b0)
    begin
      if (n > 60)
        fail_timeout();
      n++;
      wb_xfer(1'b0, `ADDR_STATUS, 8'h00, s);
    end
  endtask : wait_switch
  // One-cycle pulse: 0 clear-watchdog, 1 halt, 2 watchdog overflow
  task pulse(input int which);
    @(posedge clk_i);
    if (which == 0)
      clr_wdt_i <= 1'b1;
    else if (which == 1)
      halt_i <= 1'b1;
    else
      wdt_overflow_i <= 1'b1;
    @(posedge clk_i);
    clr_wdt_i <= 1'b0;
    halt_i <= 1'b0;
    wdt_overflow_i <= 1'b0;
  endtask : pulse
  // Reset values, unmapped address, idle outputs
  task t_reset_values;
    logic [7:0] d;
    wb_xfer(1'b0, `ADDR_CLK_CTRL, 8'h00, d);
    chk(d, 8'h00);
    wb_xfer(1'b0, `ADDR_OSC_CTRL, 8'h00, d);
    chk(d, 8'h01);
    wb_xfer(1'b0, `ADDR_WAKE_EN, 8'h00, d);
    chk(d, 8'h00);
    wb_xfer(1'b0, 8'h10, 8'h00, d);
    chk(d, 8'h00);
    wb_xfer(1'b0, `ADDR_STATUS, 8'h00, d);
    chk(d[`STAT_PDF], 1'b0);
    chk(cpu_clk_en_o, 1'b1);
  endtask : t_reset_values
  // Every fast divisor code, ending back on undivided
  task t_fast_divisors;
    logic [7:0] d;
    for (int i = 1; i < 8; i++)
    begin
      wb_xfer(1'b1, `ADDR_CLK_CTRL, {i[2:0] % 3'h7, 5'h00}, d);
      wait_switch();
      chk(sys_clk_select_o, i[2:0] % 3'h7);
    end
  endtask : t_fast_divisors
  // Into slow mode with the fast source off, then back
  task t_slow_switch;
    logic [7:0] d;
    wb_xfer(1'b1, `ADDR_OSC_CTRL, 8'h00, d);
    wb_xfer(1'b1, `ADDR_CLK_CTRL, 8'he4, d);
    wait_switch();
    chk(sys_clk_select_o, `SEL_SUB);
    wb_xfer(1'b0, `ADDR_STATUS, 8'h00, d);
    chk({d[`STAT_SLOW], d[`OSC_EXT_LS]}, 2'b11);
    chk(osc_en_o.int_hs, 1'b0);
    wb_xfer(1'b1, `ADDR_CLK_CTRL, 8'h00, d);
    repeat (2) @(posedge clk_i);
    #1;
    chk(sys_clk_select_o, `SEL_SUB);
    wait_switch();
    chk(sys_clk_select_o, 3'h0);
    wb_xfer(1'b0, `ADDR_STATUS, 8'h00, d);
    chk(d[`OSC_INT_HS], 1'b1);
    wb_xfer(1'b1, `ADDR_OSC_CTRL, 8'h01, d);
  endtask : t_slow_switch
  // Wait for wake pulse and check what comes with it
  task wait_wake(input logic take, input logic pcsp);
    int n;
    n = 0;
    while (wake_o !== 1'b1)
    begin
      if (n > 300)
        fail_timeout();
      n++;
      @(posedge clk_i);
      #1;
    end
    chk({cpu_clk_en_o, irq_take_o, pc_sp_reset_o}, {1'b1, take, pcsp});
  endtask : wait_wake
  // All four low-power modes; a pin wakes mode 0, an interrupt modes 1 and 2, the watchdog mode 3
  task t_halt_modes;
    logic [7:0] d;
    for (int m = 0; m < 4; m++)
    begin
      wb_xfer(1'b1, `ADDR_CLK_CTRL, {6'h0, m[1:0]}, d);
      wb_xfer(1'b1, `ADDR_WAKE_EN, 8'h01, d);
      irq_en_i <= (m == 1 || m == 2) ? 8'h01 : 8'h00;
      stack_full_i <= (m == 2);
      @(posedge clk_i);
      halt_i <= 1'b1;
      #1;
      chk(wdt_clear_o, 1'b1);
      @(posedge clk_i);
      halt_i <= 1'b0;
      #1;
      chk({cpu_clk_en_o, hs_clk_gate_o, sub_clk_gate_o}, {1'b0, m[1:0]});
      wb_xfer(1'b0, `ADDR_STATUS, 8'h00, d);
      chk({d[`STAT_TO], d[`STAT_PDF]}, 2'b01);
      @(posedge clk_i);
      if (m == 0)
        port_pin_i <= 8'hfe;
      else if (m < 3)
        irq_req_i <= 8'h01;
      else
        wdt_overflow_i <= 1'b1;
      @(posedge clk_i);
      wdt_overflow_i <= 1'b0;
      wait_wake(m == 1, m == 3);
      wb_xfer(1'b0, `ADDR_STATUS, 8'h00, d);
      chk({d[`STAT_TO], d[`STAT_PDF]}, {m == 3, 1'b1});
      port_pin_i <= 8'hff;
      irq_req_i <= 8'h00;
      pulse(0);
      wb_xfer(1'b0, `ADDR_STATUS, 8'h00, d);
      chk(d[`STAT_PDF], 1'b0);
      repeat (10) @(posedge clk_i);
    end
  endtask : t_halt_modes
  // A request already pending at halt must not wake
  task t_pending_irq;
    logic [7:0] d;
    int woke;
    woke = 0;
    wb_xfer(1'b1, `ADDR_CLK_CTRL, 8'h03, d);
    irq_en_i <= 8'h02;
    irq_req_i <= 8'h02;
    pulse(1);
    repeat (20)
    begin
      @(posedge clk_i);
      #1;
      if (wake_o === 1'b1)
        woke++;
    end
    chk(woke, 0);
    pulse(2);
    @(posedge clk_i);
    #1;
    wait_wake(1'b0, 1'b1);
    @(posedge clk_i);
    irq_req_i <= 8'h00;
  endtask : t_pending_irq
  // A halt seen while the clock enable is low must change nothing
  task t_freeze;
    @(posedge clk_i);
    ce_i <= 1'b0;
    halt_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk({cpu_clk_en_o, wdt_clear_o}, 2'b10);
    @(posedge clk_i);
    halt_i <= 1'b0;
    ce_i <= 1'b1;
    #1;
    chk(cpu_clk_en_o, 1'b1);
  endtask : t_freeze
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_reset_values();
    t_fast_divisors();
    t_slow_switch();
    t_halt_modes();
    t_pending_irq();
    t_freeze();
    tally_and_finish();
  end
endmodule : power_mode_controller_tb

/* File: core/power_mode_controller.sv */
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "power_mode_map.svh"

module power_mode_controller
  import power_mode_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int IRQ_W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic halt_i,
  input wire logic clr_wdt_i,
  input wire logic [IRQ_W-1:0] irq_req_i,
  input wire logic [IRQ_W-1:0] irq_en_i,
  input wire logic stack_full_i,
  input wire logic wdt_overflow_i,
  input wire logic [PORT_W-1:0] port_pin_i,
  input wire osc_vec_t osc_ready_i,
  output logic cpu_clk_en_o,
  output logic hs_clk_gate_o,
  output logic sub_clk_gate_o,
  output logic [2:0] sys_clk_select_o,
  output osc_vec_t osc_en_o,
  output logic wdt_clear_o,
  output logic wake_o,
  output logic irq_take_o,
  output logic pc_sp_reset_o
);

  localparam int IN_W = PORT_W + 4;
  localparam int SW_CYC = `SW_DELAY_CYC;

  // Refuse widths the byte-wide registers cannot hold
  if (PORT_W < 1 || PORT_W > 8)
  begin : g_bad_port
    $error("PORT_W must be 1 to 8");
  end
  if (IRQ_W < 1 || SW_CYC < 1 || SW_CYC > 7)
  begin : g_bad_cnt
    $error("IRQ_W or switch delay out of range");
  end

  // Software-visible state
  clk_ctrl_t clk_ctrl_reg; // Requested clock setup and keep bits
  osc_vec_t osc_sw_reg; // Software oscillator enables
  logic [PORT_W-1:0] wake_en_reg; // Per-pin wake enables
  logic pdf_reg; // Power-down flag
  logic to_reg; // Watchdog time-out flag

  // Clock setup actually in force
  logic [2:0] eff_sel_reg;
  logic eff_hs_src_reg;
  logic eff_ls_src_reg;

  // Sequencer state
  pm_state_t state_reg;
  pm_state_t state_next;
  logic [2:0] sw_cnt_reg;
  logic [2:0] sw_cnt_next;
  logic [1:0] mode_reg; // Keep bits caught at halt {hs, ls}
  logic [IRQ_W-1:0] irq_snap_reg; // Requests already pending at halt
  logic [IRQ_W-1:0] irq_wake_reg; // Requests that woke us
  logic wdt_wake_reg;

  // Oscillator enables and stable flags
  osc_vec_t osc_en_reg;
  osc_vec_t osc_en_next;
  osc_vec_t en_prev_reg;
  osc_vec_t stab_reg;

  // Pin and ready synchronisers
  logic [IN_W-1:0] s1_reg;
  logic [IN_W-1:0] s2_reg;
  logic [IN_W-1:0] s3_reg;
  logic [IN_W-1:0] filt_reg;
  logic [PORT_W-1:0] pin_prev_reg;

  // Bus slave
  logic ack_reg;
  logic [7:0] rd_reg;
  logic wake_reg;
  logic irq_take_reg;
  logic pc_sp_reg;

  // One-hot oscillator feeding a given setup
  function automatic osc_vec_t src_of(input logic [2:0] sel, input logic hs,
                                      input logic ls);
    osc_vec_t v;
    v = '0;
    if (sel == `SEL_SUB)
      v[ls ? `OSC_EXT_LS : `OSC_INT_LS] = 1'b1;
    else
      v[hs ? `OSC_EXT_HS : `OSC_INT_HS] = 1'b1;
    return v;
  endfunction : src_of

  // Decoding and selection
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire wr_hit = bus_req & ack_reg & wb_we_i & wb_sel_i[0];
  wire wr_clk = wr_hit & (wb_adr_i == `ADDR_CLK_CTRL);
  wire wr_osc = wr_hit & (wb_adr_i == `ADDR_OSC_CTRL);
  wire wr_wake = wr_hit & (wb_adr_i == `ADDR_WAKE_EN);
  wire in_lp = (state_reg == st_low_power);
  wire halt_ok = halt_i & (state_reg == st_run);
  wire osc_vec_t eff_src = src_of(eff_sel_reg, eff_hs_src_reg, eff_ls_src_reg);
  wire osc_vec_t new_src = src_of(clk_ctrl_reg.sys_clk_select,
    clk_ctrl_reg.hs_source_select, clk_ctrl_reg.low_freq_source_select);
  wire sw_req = (clk_ctrl_reg.sys_clk_select != eff_sel_reg)
    | (clk_ctrl_reg.hs_source_select != eff_hs_src_reg)
    | (clk_ctrl_reg.low_freq_source_select != eff_ls_src_reg);
  wire new_ok = |(new_src & stab_reg);
  wire eff_ok = |(eff_src & stab_reg);
  wire sw_done = new_ok & (sw_cnt_reg == 3'(SW_CYC - 1));
  wire [PORT_W-1:0] pin_filt = filt_reg[IN_W-1:4];
  wire pin_evt = |(pin_prev_reg & ~pin_filt & wake_en_reg);
  wire [IRQ_W-1:0] irq_new = irq_req_i & ~irq_snap_reg;
  wire wake_any = pin_evt | (|irq_new) | wdt_overflow_i;
  wire restart_done = (state_reg == st_restart) & eff_ok;
  wire [7:0] status = {state_reg == st_switch ? 1'b0 : 1'b0, 7'h00}
    | (8'(eff_sel_reg == `SEL_SUB) << `STAT_SLOW)
    | (8'(state_reg == st_switch) << `STAT_BUSY)
    | (8'(to_reg) << `STAT_TO) | (8'(pdf_reg) << `STAT_PDF)
    | {4'h0, stab_reg};
  wire [7:0] rd_mux = (wb_adr_i == `ADDR_CLK_CTRL) ? 8'(clk_ctrl_reg & 8'hef) :
    (wb_adr_i == `ADDR_OSC_CTRL) ? {4'h0, osc_sw_reg} :
    (wb_adr_i == `ADDR_STATUS) ? status :
    (wb_adr_i == `ADDR_WAKE_EN) ? 8'(wake_en_reg) : 8'h00;

  // Outputs
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = {24'h000000, rd_reg};
  assign cpu_clk_en_o = (state_reg == st_run) | (state_reg == st_switch);
  assign hs_clk_gate_o = ~in_lp | mode_reg[1];
  assign sub_clk_gate_o = ~in_lp | mode_reg[0];
  assign sys_clk_select_o = eff_sel_reg;
  assign osc_en_o = osc_en_reg;
  assign wdt_clear_o = halt_ok & ce_i;
  assign wake_o = wake_reg;
  assign irq_take_o = irq_take_reg;
  assign pc_sp_reset_o = pc_sp_reg;

  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    sw_cnt_next = 3'h0;
    unique case (state_reg)
      st_run:
      begin
        // Halt beats a pending clock change
        if (halt_ok)
          state_next = st_low_power;
        else if (sw_req)
          state_next = st_switch;
      end
      st_switch:
      begin
        // Count only while the target oscillator is stable
        if (!sw_req)
          state_next = st_run;
        else if (sw_done)
          state_next = st_run;
        else if (new_ok)
          sw_cnt_next = sw_cnt_reg + 3'h1;
      end
      st_low_power:
      begin
        if (wake_any)
          state_next = st_restart;
      end
      st_restart:
      begin
        if (eff_ok)
          state_next = st_run;
      end
    endcase
  end

  // Oscillator enables: software, plus whatever the clock in use or in
  // arrival needs; keep bits decide what survives a halt
  always_comb
  begin
    osc_en_next = osc_sw_reg | eff_src;
    if (state_reg == st_switch)
      osc_en_next = osc_en_next | new_src;
    if (in_lp)
    begin
      osc_en_next.int_hs = osc_en_next.int_hs & mode_reg[1];
      osc_en_next.ext_hs = osc_en_next.ext_hs & mode_reg[1];
      osc_en_next.int_ls = osc_en_next.int_ls & mode_reg[0];
      osc_en_next.ext_ls = osc_en_next.ext_ls & mode_reg[0];
    end
  end

  // Synchronisers: three stages, a change counts when stages two and
  // three agree, so a single-cycle glitch never reaches the wake logic
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s1_reg <= {{PORT_W{1'b1}}, 4'h0};
      s2_reg <= {{PORT_W{1'b1}}, 4'h0};
      s3_reg <= {{PORT_W{1'b1}}, 4'h0};
      filt_reg <= {{PORT_W{1'b1}}, 4'h0};
      pin_prev_reg <= '1;
    end
    else if (ce_i)
    begin
      s1_reg <= {port_pin_i, osc_ready_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
      pin_prev_reg <= pin_filt;
    end
  end

  // Stable flags: an enable edge forces one low cycle first
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      osc_en_reg <= osc_vec_t'(`RST_OSC_CTRL);
      en_prev_reg <= '0;
      stab_reg <= '0;
    end
    else if (ce_i)
    begin
      osc_en_reg <= osc_en_next;
      en_prev_reg <= osc_en_reg;
      stab_reg <= osc_en_reg & en_prev_reg & filt_reg[3:0];
    end
  end

  // Bus slave: ack one cycle after the request, write at the ack edge
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ack_reg <= 1'b0;
      rd_reg <= 8'h00;
      clk_ctrl_reg <= clk_ctrl_t'(`RST_CLK_CTRL);
      osc_sw_reg <= osc_vec_t'(`RST_OSC_CTRL);
      wake_en_reg <= PORT_W'(`RST_WAKE_EN);
    end
    else if (ce_i)
    begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req & ~ack_reg)
        rd_reg <= rd_mux;
      if (wr_clk)
        clk_ctrl_reg <= clk_ctrl_t'(wb_dat_i[7:0] & 8'hef);
      if (wr_osc)
        osc_sw_reg <= osc_vec_t'(wb_dat_i[3:0]);
      if (wr_wake)
        wake_en_reg <= wb_dat_i[PORT_W-1:0];
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= st_run;
      sw_cnt_reg <= 3'h0;
      eff_sel_reg <= 3'h0;
      eff_hs_src_reg <= 1'b0;
      eff_ls_src_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      sw_cnt_reg <= sw_cnt_next;
      if ((state_reg == st_switch) & sw_req & sw_done)
      begin
        eff_sel_reg <= clk_ctrl_reg.sys_clk_select;
        eff_hs_src_reg <= clk_ctrl_reg.hs_source_select;
        eff_ls_src_reg <= clk_ctrl_reg.low_freq_source_select;
      end
    end
  end

  // Halt capture and wake cause
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      mode_reg <= 2'h0;
      irq_snap_reg <= '0;
      irq_wake_reg <= '0;
      wdt_wake_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (halt_ok)
      begin
        mode_reg <= {clk_ctrl_reg.hs_osc_keep_alive,
                     clk_ctrl_reg.ls_osc_keep_alive};
        irq_snap_reg <= irq_req_i;
      end
      if (in_lp & wake_any)
      begin
        irq_wake_reg <= irq_new;
        wdt_wake_reg <= wdt_overflow_i;
      end
    end
  end

  // Flags: hardware set wins over the clearing event in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pdf_reg <= 1'b0;
      to_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      pdf_reg <= halt_ok | (pdf_reg & ~clr_wdt_i);
      to_reg <= (in_lp & wdt_overflow_i) | (to_reg & ~halt_ok);
    end
  end

  // Wake pulses; a pending interrupt stays with the interrupt controller
  // when it cannot be taken now
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wake_reg <= 1'b0;
      irq_take_reg <= 1'b0;
      pc_sp_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      wake_reg <= restart_done;
      irq_take_reg <= restart_done & ~wdt_wake_reg & ~stack_full_i
        & (|(irq_wake_reg & irq_en_i));
      pc_sp_reg <= restart_done & wdt_wake_reg;
    end
  end

  // Checks; frozen cycles are not judged
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i || !ce_i);

  sequence halt_seq;
    halt_i && state_reg == st_run;
  endsequence

  sequence wake_seq;
    state_reg == st_low_power && wake_any ##1 state_reg == st_restart;
  endsequence

  chk_halt_pdf_set: assert property (halt_seq |=> pdf_reg && state_reg == st_low_power)
    else $error("halt did not set power-down flag");
  chk_halt_to_clear: assert property (halt_seq |=> !to_reg)
    else $error("halt did not clear time-out flag");
  chk_halt_wdt_clear: assert property (halt_seq |-> wdt_clear_o ##1 !cpu_clk_en_o)
    else $error("halt did not clear watchdog or gate cpu");
  chk_pdf_hold: assert property (pdf_reg && !clr_wdt_i |=> pdf_reg)
    else $error("power-down flag lost without clear");
  chk_sleep_gates: assert property (in_lp && mode_reg == 2'h0 |->
    !hs_clk_gate_o && !sub_clk_gate_o && !cpu_clk_en_o)
    else $error("sleep left a clock running");
  chk_idle_sub: assert property (in_lp && mode_reg == 2'h1 |->
    !hs_clk_gate_o && sub_clk_gate_o)
    else $error("sub-only idle gates wrong");
  chk_idle_both: assert property (in_lp && mode_reg == 2'h3 |->
    hs_clk_gate_o && sub_clk_gate_o && !cpu_clk_en_o)
    else $error("both-clock idle gates wrong");
  chk_idle_fast: assert property (in_lp && mode_reg == 2'h2 |->
    hs_clk_gate_o && !sub_clk_gate_o)
    else $error("fast-only idle gates wrong");
  chk_old_irq_quiet: assert property (in_lp && !pin_evt && !wdt_overflow_i
    && (irq_req_i & ~irq_snap_reg) == '0 |=> in_lp)
    else $error("stale request woke the device");
  chk_pin_wake: assert property (in_lp && pin_evt |=> state_reg == st_restart)
    else $error("enabled pin edge did not wake");
  chk_wdt_wake: assert property (wake_seq and (in_lp && wdt_overflow_i)
    |-> ##[1:1000] pc_sp_reset_o)
    else $error("watchdog wake without pc reset");
  // Wake pulse is launched by the same edge that returns to run
  chk_restart_stable: assert property (state_reg == st_restart ##1 state_reg == st_run
    |-> $past(eff_ok) && wake_o)
    else $error("resumed before oscillator stable");
  chk_switch_delay: assert property ($changed(eff_sel_reg) |->
    $past(sw_cnt_reg) == 3'(SW_CYC - 1) && $past(new_ok))
    else $error("clock switched before delay");
  chk_stable_low: assert property ($rose(osc_en_reg[`OSC_INT_HS]) |=>
    !stab_reg[`OSC_INT_HS])
    else $error("stable flag not low after enable");

endmodule : power_mode_controller

/* File: core/power_mode_map.svh */
`ifndef POWER_MODE_MAP_SVH
`define POWER_MODE_MAP_SVH

// Register byte addresses on the bus
`define ADDR_CLK_CTRL 8'h00
`define ADDR_OSC_CTRL 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_WAKE_EN 8'h0c

// Reset values
`define RST_CLK_CTRL 8'h00
`define RST_OSC_CTRL 4'h1
`define RST_WAKE_EN 8'h00

// Clock select code that picks the sub clock
`define SEL_SUB 3'h7

// Oscillator bit positions in enable, ready and stable vectors
`define OSC_INT_HS 0
`define OSC_EXT_HS 1
`define OSC_EXT_LS 2
`define OSC_INT_LS 3

// Status register field positions
`define STAT_PDF 4
`define STAT_TO 5
`define STAT_BUSY 6
`define STAT_SLOW 7

// Clock switching delay, in system clock periods, and the clock period
`define SW_DELAY_TSYS 4
`define SYS_CLK_NS 40
`define SW_DELAY_CYC ((`SW_DELAY_TSYS * `SYS_CLK_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

/* File: core/power_mode_pkg.sv */
package power_mode_pkg;

  // Controller states
  typedef enum logic [1:0] {
    st_run,
    st_switch,
    st_low_power,
    st_restart
  } pm_state_t;

  // Clock control register layout
  typedef struct packed {
    logic [2:0] sys_clk_select;
    logic spare;
    logic hs_source_select;
    logic low_freq_source_select;
    logic hs_osc_keep_alive;
    logic ls_osc_keep_alive;
  } clk_ctrl_t;

  // One bit per oscillator
  typedef struct packed {
    logic int_ls;
    logic ext_ls;
    logic ext_hs;
    logic int_hs;
  } osc_vec_t;

endpackage : power_mode_pkg
